//--- logic/sarc_top.sv
/*
 * Control and result holding logic of an eight input, 10-bit successive
 * approximation converter: start control, single and scan sequencing,
 * conversion timing, end flag, interrupt and four result registers.
 * Assumes the analog core samples on ANA_SAMPLE_O and presents its
 * result on ANA_DATA_I by the end of the timed conversion.
 */
//
// Contract
// - Result sits left-justified in bits 15..6.
// - Low six result bits always read zero.
// - Upper byte read copies low byte to latch.
// - Results clear to zero at reset.
// - Four read-only results; writes ignored.
// - Inputs 0-3 group 0, 4-7 group 1.
// - Inputs n and n+4 share result n.
// - Single mode converts one channel per start.
// - Scan repeats one to four group channels.
// - Start by software or external trigger edge.
// - Conversion end can raise an interrupt.
// - At least 4.4 us per channel.
// - Start bit: self-clears single, scan runs on.
// - End flag set at end; read-then-zero clears.
// - Mode bit selects scan; enable gates interrupt.
// - Time select picks 134 or 70 states.
`timescale 1ns/1ps
module sarc_top
	import sarc_pkg::*;
(
	input  wire logic              CLK_I,
	input  wire logic              SRST_I,
	input  wire logic [ADDR_W-1:0] BUS_ADDR_I,
	input  wire logic              BUS_RD_I,
	input  wire logic              BUS_WR_I,
	input  wire logic [BYTE_W-1:0] BUS_WDATA_I,
	output logic      [BYTE_W-1:0] BUS_RDATA_O,
	input  wire logic              EXTERNAL_START_TRIGGER_I,
	input  wire logic              STANDBY_I,
	output logic                   ANA_SAMPLE_O,
	output logic      [CH_W-1:0]   ANA_CH_O,
	input  wire logic [RES_W-1:0]  ANA_DATA_I,
	output logic                   CONVERSION_END_IRQ_O
);

	logic                            trg_meta_r;
	logic                            trg_sync_r;
	logic                            trg_prev_r;
	logic                            trg_edge_w;
	sarc_csr_type                    csr_r;
	sarc_csr_type                    csr_nxt;
	sarc_sel_type                    sel_r;
	sarc_sel_type                    sel_nxt;
	logic [NUM_RES-1:0][RES_W-1:0]   res_r;
	logic [NUM_RES-1:0][RES_W-1:0]   res_nxt;
	logic [BYTE_W-1:0]               tmp_r;
	logic [BYTE_W-1:0]               tmp_nxt;
	logic [BYTE_W-1:0]               rdata_r;
	logic [BYTE_W-1:0]               rdata_nxt;
	logic                            armed_r;
	logic                            armed_nxt;
	sarc_state_type                  state_r;
	sarc_state_type                  state_nxt;
	logic [CNT_W-1:0]                cnt_r;
	logic [CNT_W-1:0]                cnt_nxt;
	logic [CH_W-1:0]                 ch_r;
	logic [CH_W-1:0]                 ch_nxt;
	logic                            sample_r;
	logic                            sample_nxt;
	logic                            done_w;
	logic                            last_w;
	logic [SLOT_W-1:0]               slot_w;
	logic [SLOT_W-1:0]               rd_slot_w;
	logic                            up_rd_w;
	logic                            lo_rd_w;
	logic [BYTE_W-1:0]               rd_low_w;
	logic [CNT_W-1:0]                load_w;

	// The trigger pin is asynchronous, so it passes two flops first.
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			trg_meta_r <= 1'b1;
			trg_sync_r <= 1'b1;
			trg_prev_r <= 1'b1;
		end else begin
			trg_meta_r <= EXTERNAL_START_TRIGGER_I;
			trg_sync_r <= trg_meta_r;
			trg_prev_r <= trg_sync_r;
		end
	end

	// A falling edge of the synchronised trigger requests a start.
	assign trg_edge_w = trg_prev_r & ~trg_sync_r;

	// Decode helpers for result byte reads, scan channel slot, last channel and time select.
	assign rd_slot_w = SLOT_W'(BUS_ADDR_I >> 1);
	assign up_rd_w   = BUS_RD_I && (BUS_ADDR_I < OFS_CSR) && !BUS_ADDR_I[0];
	assign lo_rd_w   = BUS_RD_I && (BUS_ADDR_I < OFS_CSR) && BUS_ADDR_I[0];
	assign rd_low_w  = {res_r[rd_slot_w][LOW_W-1:0], {RES_LSB{1'b0}}};
	assign slot_w    = ch_r[SLOT_W-1:0];
	assign last_w    = !csr_r.scan || (slot_w == sel_r.ch);
	assign load_w    = csr_r.tsel ? FAST_LOAD : SLOW_LOAD;

	// Register port, start control and sequencer share one next-state
	// process so that hardware sets are ordered after software clears.
	always_comb begin
		csr_nxt    = csr_r;
		sel_nxt    = sel_r;
		res_nxt    = res_r;
		tmp_nxt    = tmp_r;
		rdata_nxt  = rdata_r;
		armed_nxt  = armed_r;
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		ch_nxt     = ch_r;
		sample_nxt = 1'b0;
		done_w     = 1'b0;
		// Writes to result offsets fall through and change nothing.
		if (BUS_WR_I && (BUS_ADDR_I == OFS_CSR)) begin
			csr_nxt.ie    = BUS_WDATA_I[BIT_IE];
			csr_nxt.scan  = BUS_WDATA_I[BIT_SCAN];
			csr_nxt.tsel  = BUS_WDATA_I[BIT_TSEL];
			csr_nxt.start = BUS_WDATA_I[BIT_START];
			if (!BUS_WDATA_I[BIT_FLAG] && armed_r) begin
				csr_nxt.flag = 1'b0;
			end
			armed_nxt = 1'b0;
		end
		if (BUS_WR_I && (BUS_ADDR_I == OFS_SEL)) begin
			sel_nxt.trg_en = BUS_WDATA_I[BIT_TRGE];
			sel_nxt.group  = BUS_WDATA_I[BIT_GRP];
			sel_nxt.ch     = BUS_WDATA_I[SLOT_W-1:0];
		end
		// Reads: upper byte loads the latch, lower byte comes from it.
		if (BUS_RD_I) begin
			rdata_nxt = '0;
			if (up_rd_w) begin
				rdata_nxt = res_r[rd_slot_w][RES_W-1 -: BYTE_W];
				tmp_nxt   = rd_low_w;
			end else if (lo_rd_w) begin
				rdata_nxt = tmp_r;
			end else if (BUS_ADDR_I == OFS_CSR) begin
				rdata_nxt[BIT_FLAG]  = csr_r.flag;
				rdata_nxt[BIT_IE]    = csr_r.ie;
				rdata_nxt[BIT_START] = csr_r.start;
				rdata_nxt[BIT_SCAN]  = csr_r.scan;
				rdata_nxt[BIT_TSEL]  = csr_r.tsel;
				if (csr_r.flag) begin
					armed_nxt = 1'b1;
				end
			end else if (BUS_ADDR_I == OFS_SEL) begin
				rdata_nxt[BIT_TRGE]     = sel_r.trg_en;
				rdata_nxt[BIT_GRP]      = sel_r.group;
				rdata_nxt[SLOT_W-1:0]   = sel_r.ch;
			end
		end
		if (trg_edge_w && sel_r.trg_en) begin
			csr_nxt.start = 1'b1;
		end
		if (STANDBY_I) begin
			csr_nxt.start = 1'b0;
		end
		unique case (state_r)
			ST_IDLE: begin
				if (csr_r.start) begin
					state_nxt  = ST_CONV;
					cnt_nxt    = load_w;
					sample_nxt = 1'b1;
					// Scan begins at the first input of the group.
					ch_nxt = csr_r.scan ? {sel_r.group, {SLOT_W{1'b0}}}
					                    : {sel_r.group, sel_r.ch};
				end
			end
			ST_CONV: begin
				if (!csr_r.start) begin
					// Software stop abandons the conversion in flight.
					state_nxt = ST_IDLE;
				end else if (cnt_r == CNT_ZERO) begin
					done_w          = 1'b1;
					res_nxt[slot_w] = ANA_DATA_I;
					if (last_w) begin
						csr_nxt.flag = 1'b1;
					end
					if (!csr_r.scan) begin
						csr_nxt.start = 1'b0;
						state_nxt     = ST_IDLE;
					end else begin
						cnt_nxt    = load_w;
						sample_nxt = 1'b1;
						ch_nxt     = last_w ? {sel_r.group, {SLOT_W{1'b0}}}
						           : {sel_r.group, SLOT_W'(slot_w + 1'b1)};
					end
				end else begin
					cnt_nxt = cnt_r - CNT_ONE;
				end
			end
		endcase
	end

	// State registers of the port and sequencer.
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			csr_r    <= '0;
			sel_r    <= '0;
			res_r    <= '0;
			tmp_r    <= '0;
			rdata_r  <= '0;
			armed_r  <= 1'b0;
			state_r  <= ST_IDLE;
			cnt_r    <= CNT_ZERO;
			ch_r     <= '0;
			sample_r <= 1'b0;
		end else begin
			csr_r    <= csr_nxt;
			sel_r    <= sel_nxt;
			res_r    <= res_nxt;
			tmp_r    <= tmp_nxt;
			rdata_r  <= rdata_nxt;
			armed_r  <= armed_nxt;
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			ch_r     <= ch_nxt;
			sample_r <= sample_nxt;
		end
	end

	assign BUS_RDATA_O  = rdata_r;
	assign ANA_SAMPLE_O = sample_r;
	assign ANA_CH_O     = ch_r;
	// Both terms are flops, so the request is glitch free.
	assign CONVERSION_END_IRQ_O = csr_r.flag & csr_r.ie;

	// Cycles since the last sample pulse, read only by assertions.
	logic [CNT_W-1:0] age_r;
	always_ff @(posedge CLK_I) begin
		if (SRST_I || sample_nxt) begin
			age_r <= CNT_ZERO;
		end else if (age_r != '1) begin
			age_r <= age_r + CNT_ONE;
		end
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SRST_I);

	sequence s_upper_rd;
		up_rd_w;
	endsequence

	sequence s_lower_rd;
		lo_rd_w;
	endsequence

	sequence s_scan_wrap;
		done_w && csr_r.scan && last_w && csr_r.start && !STANDBY_I;
	endsequence

	property p_low_zero;
		s_lower_rd |=> (BUS_RDATA_O[RES_LSB-1:0] == '0);
	endproperty
	a_low_zero: assert property (p_low_zero)
		else $error("low result bits not zero");

	property p_latch;
		s_upper_rd |=> (tmp_r == $past(rd_low_w));
	endproperty
	a_latch: assert property (p_latch)
		else $error("latch not loaded on upper read");

	property p_latch_hold;
		!up_rd_w |=> $stable(tmp_r);
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("latch changed without upper read");

	property p_word_pair;
		s_upper_rd ##1 s_lower_rd |=> (BUS_RDATA_O == $past(tmp_r));
	endproperty
	a_word_pair: assert property (p_word_pair)
		else $error("lower byte not served from latch");

	property p_reset;
		@(posedge CLK_I) disable iff (1'b0)
		SRST_I |=> (res_r == '0) && (csr_r == '0);
	endproperty
	a_reset: assert property (p_reset)
		else $error("results not cleared by reset");

	property p_read_only;
		!done_w |=> $stable(res_r);
	endproperty
	a_read_only: assert property (p_read_only)
		else $error("result changed without conversion");

	property p_map;
		done_w |=> (res_r[$past(slot_w)] == $past(ANA_DATA_I));
	endproperty
	a_map: assert property (p_map)
		else $error("result stored in wrong register");

	property p_single;
		done_w && !csr_r.scan |=> !csr_r.start && (state_r == ST_IDLE);
	endproperty
	a_single: assert property (p_single)
		else $error("single mode did not stop");

	property p_scan_wrap;
		s_scan_wrap |=> sample_r && (slot_w == '0);
	endproperty
	a_scan_wrap: assert property (p_scan_wrap)
		else $error("scan did not restart at first channel");

	property p_trigger;
		trg_edge_w && sel_r.trg_en && !STANDBY_I |=> csr_r.start;
	endproperty
	a_trigger: assert property (p_trigger)
		else $error("trigger edge did not start");

	property p_irq;
		done_w && last_w && csr_r.ie |=> CONVERSION_END_IRQ_O;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt not raised at end");

	property p_min_time;
		done_w |-> (age_r >= CNT_W'(MIN_CYC - 1));
	endproperty
	a_min_time: assert property (p_min_time)
		else $error("conversion shorter than minimum");

	property p_time_sel;
		done_w |-> (age_r == load_w) || $past(csr_r.tsel) != csr_r.tsel;
	endproperty
	a_time_sel: assert property (p_time_sel)
		else $error("conversion length wrong for time select");

	property p_flag;
		done_w && last_w |=> csr_r.flag;
	endproperty
	a_flag: assert property (p_flag)
		else $error("end flag not set");

endmodule : sarc_top

//--- inc/sarc_pkg.sv
/*
 * Shared constants and types of the converter control and result block.
 * Assumes a 40 MHz system clock and an 8-bit CPU register port.
 */
package sarc_pkg;

	// Clock and conversion timing.
	localparam int CLK_MHZ      = 40;
	localparam int REF_MHZ      = 16;
	localparam int MIN_CONV_NS  = 4400;
	localparam int STATES_SLOW  = 134;
	localparam int STATES_FAST  = 70;
	localparam int MIN_CYC      = (MIN_CONV_NS * CLK_MHZ + 999) / 1000;
	localparam int SLOW_RAW     = (STATES_SLOW * CLK_MHZ + REF_MHZ - 1)
	                              / REF_MHZ;
	localparam int FAST_RAW     = (STATES_FAST * CLK_MHZ + REF_MHZ - 1)
	                              / REF_MHZ;
	localparam int SLOW_CYC     = (SLOW_RAW > MIN_CYC) ? SLOW_RAW : MIN_CYC;
	localparam int FAST_CYC     = (FAST_RAW > MIN_CYC) ? FAST_RAW : MIN_CYC;
	localparam int CNT_W        = 9;
	localparam logic [CNT_W-1:0] SLOW_LOAD = CNT_W'(SLOW_CYC - 1);
	localparam logic [CNT_W-1:0] FAST_LOAD = CNT_W'(FAST_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO  = '0;
	localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);

	// Register port layout.
	localparam int ADDR_W   = 4;
	localparam int BYTE_W   = 8;
	localparam logic [ADDR_W-1:0] OFS_CSR = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_SEL = 4'h9;
	localparam int BIT_FLAG  = 7;
	localparam int BIT_IE    = 6;
	localparam int BIT_START = 5;
	localparam int BIT_SCAN  = 4;
	localparam int BIT_TSEL  = 3;
	localparam int BIT_TRGE  = 7;
	localparam int BIT_GRP   = 2;

	// Result layout.
	localparam int RES_W    = 10;
	localparam int RES_LSB  = 6;
	localparam int NUM_RES  = 4;
	localparam int CH_W     = 3;
	localparam int SLOT_W   = 2;
	localparam int LOW_W    = RES_W - BYTE_W;

	typedef struct packed {
		logic flag;
		logic ie;
		logic start;
		logic scan;
		logic tsel;
	} sarc_csr_type;

	typedef struct packed {
		logic              trg_en;
		logic              group;
		logic [SLOT_W-1:0] ch;
	} sarc_sel_type;

	typedef enum logic [0:0] {ST_IDLE, ST_CONV} sarc_state_type;

endpackage : sarc_pkg

//--- tb/sarc_ana_model.sv
/*
 * Behavioural model of the analog core behind the converter control block.
 * Assumes the block pulses sample_i once per channel and takes data_o
 * when that channel's timed conversion ends.
 */
`timescale 1ns/1ps
module sarc_ana_model
	import sarc_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	input  wire logic              sample_i,
	input  wire logic [CH_W-1:0]   ch_i,
	output logic      [RES_W-1:0]  data_o
);
	// Each channel gets its own code with bit 0 always set and bit 1 equal to channel bit 0,
	// so that a lost or shifted low pair shows up at the lower result byte.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			data_o <= '1;
		end else if (sample_i) begin
			data_o <= {ch_i, ch_i, ch_i, 1'b1};
		end
	end
endmodule : sarc_ana_model

//--- tb/testbench.sv
/*
 * Self-checking bench of the converter control block: byte register
 * accesses, single, scan and triggered conversions against the analog model.
 * Assumes the register map and timing of the hand-over contract.
 */
`timescale 1ns/1ps
module testbench
	import sarc_pkg::*;
;
	logic              clk = 1'b0;
	logic              srst, rd, wr, trg, stby, samp, irq;
	logic [ADDR_W-1:0] addr;
	logic [BYTE_W-1:0] wdata, rdata, d;
	logic [CH_W-1:0]   ch;
	logic [RES_W-1:0]  adata, e;
	int                n_mismatch, cmp_count, cyc, n_samp, n;

	// The 40 MHz system clock.
	always #12.5 clk = ~clk;

	// Cycle ceiling and a count of sample pulses for the single-mode check.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (samp === 1'b1) n_samp <= n_samp + 1;
		if (cyc == 10000) begin
			n_mismatch++;
			print_verdict;
		end
	end

	sarc_top i_sarc_top (.CLK_I(clk), .SRST_I(srst), .BUS_ADDR_I(addr),
		.BUS_RD_I(rd), .BUS_WR_I(wr), .BUS_WDATA_I(wdata),
		.BUS_RDATA_O(rdata), .EXTERNAL_START_TRIGGER_I(trg),
		.STANDBY_I(stby), .ANA_SAMPLE_O(samp), .ANA_CH_O(ch),
		.ANA_DATA_I(adata), .CONVERSION_END_IRQ_O(irq));

	sarc_ana_model i_sarc_ana_model (.clk_i(clk), .srst_i(srst),
		.sample_i(samp), .ch_i(ch), .data_o(adata));

	// Expected analog code of a channel, kept apart from the model's logic.
	function automatic logic [RES_W-1:0] ev(input logic [CH_W-1:0] c);
		ev = {c, c, c, 1'b1};
	endfunction : ev

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic print_verdict;
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	// One byte access takes two cycles, so strobes never toggle twice.
	task automatic wrb(input logic [ADDR_W-1:0] a, input logic [7:0] v);
		@(negedge clk);
		addr = a;
		wdata = v;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : wrb

	task automatic rdb(input logic [ADDR_W-1:0] a, output logic [7:0] v);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		v = rdata;
	endtask : rdb

	// Word read: upper byte, then the latched lower byte on the next edge,
	// so that the pair is taken back to back as a word access would be.
	task automatic rres(input int k, input logic [RES_W-1:0] x);
		@(negedge clk);
		addr = 4'(2 * k);
		rd = 1'b1;
		@(negedge clk);
		addr = 4'(2 * k + 1);
		d = rdata;
		@(negedge clk);
		rd = 1'b0;
		chk(16'(d), 16'(x[9:2]));
		chk(16'(rdata), {8'h00, x[1:0], 6'h00});
	endtask : rres

	// Cycles from the first sample pulse to the interrupt, both bounded.
	task automatic conv(output int t);
		t = 0;
		while (samp !== 1'b1 && t < 2000) begin
			@(negedge clk);
			t++;
		end
		if (t >= 2000) n_mismatch++;
		t = 0;
		while (irq !== 1'b1 && t < 2000) begin
			@(negedge clk);
			t++;
		end
		if (t >= 2000) n_mismatch++;
	endtask : conv

	// Main sequence.
	initial begin
		{srst, rd, wr, stby, trg} = 5'h11;
		addr = '0;
		wdata = '0;
		{n_mismatch, cmp_count, cyc, n_samp} = '0;
		repeat (20) @(negedge clk);
		srst = 1'b0;
		for (int k = 0; k < 4; k++) rres(k, '0);
		for (int i = 8; i < 10; i++) begin
			rdb(4'(i), d);
			chk(16'(d), 16'h0000);
		end
		// Single fast conversion of input 5, group 1.
		wrb(OFS_SEL, 8'h05);
		wrb(OFS_CSR, 8'h68);
		conv(n);
		chk(16'(n >= FAST_CYC && n <= FAST_CYC + 2), 16'h0001);
		wrb(OFS_CSR, 8'h48);
		rdb(OFS_CSR, d);
		chk(16'(d), 16'h00C8);
		chk(16'(n_samp), 16'h0001);
		wrb(OFS_CSR, 8'h48);
		chk(16'(irq), 16'h0000);
		rdb(OFS_CSR, d);
		chk(16'(d), 16'h0048);
		e = ev(3'h5);
		rres(1, e);
		rdb(4'h0, d);
		chk(16'(d), 16'h0000);
		wrb(4'h2, 8'hFF);
		rres(1, e);
		rdb(4'h2, d);
		rdb(OFS_SEL, d);
		rdb(4'h3, d);
		chk(16'(d), {8'h00, e[1:0], 6'h00});
		// Slow conversion of input 2, then the enable gating the request.
		wrb(OFS_SEL, 8'h02);
		wrb(OFS_CSR, 8'h60);
		conv(n);
		chk(16'(n >= SLOW_CYC && n <= SLOW_CYC + 2), 16'h0001);
		rdb(OFS_CSR, d);
		wrb(OFS_CSR, 8'h80);
		chk(16'(irq), 16'h0000);
		rdb(OFS_CSR, d);
		chk(16'(d), 16'h0080);
		wrb(OFS_CSR, 8'h40);
		chk(16'(irq), 16'h0000);
		rres(2, ev(3'h2));
		// Scan of all four inputs of group 1, stopped by standby.
		wrb(OFS_SEL, 8'h07);
		rdb(OFS_SEL, d);
		chk(16'(d), 16'h0007);
		wrb(OFS_CSR, 8'h78);
		conv(n);
		chk(16'(n >= 4 * FAST_CYC && n <= 4 * FAST_CYC + 8), 16'h0001);
		for (int k = 0; k < 4; k++) rres(k, ev(3'(4 + k)));
		@(negedge clk);
		stby = 1'b1;
		@(negedge clk);
		stby = 1'b0;
		rdb(OFS_CSR, d);
		chk(16'(d), 16'h00D8);
		wrb(OFS_CSR, 8'h48);
		// Falling trigger edge starts input 3 of group 0.
		wrb(OFS_SEL, 8'h83);
		trg = 1'b0;
		conv(n);
		trg = 1'b1;
		chk(16'(irq), 16'h0001);
		rres(3, ev(3'h3));
		// Two-channel scan of group 0; the starting write also clears the
		// flag, so a stale request would end the wait at once.
		rdb(OFS_CSR, d);
		wrb(OFS_SEL, 8'h01);
		wrb(OFS_CSR, 8'h78);
		conv(n);
		chk(16'(n >= 2 * FAST_CYC && n <= 2 * FAST_CYC + 4), 16'h0001);
		wrb(OFS_CSR, 8'h48);
		rdb(OFS_CSR, d);
		chk(16'(d), 16'h00C8);
		rres(0, ev(3'h0));
		rres(1, ev(3'h1));
		// A reset in mid-run must wipe results that now hold codes.
		@(negedge clk);
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		for (int k = 0; k < 4; k++) rres(k, '0);
		print_verdict;
	end
endmodule : testbench
